// *** common/pin_mux_pkg.sv ***
// Purpose: shared constants for the test and serial pin function mux
// Assumes: pin index order b5, b0, b1, d2(tck), d3(tms), d0(tdi), d1(tdo)
// Notes:   select codes are held by the system integration module
package pin_mux_pkg;
  // pin indices within the seven-pin vectors
  localparam int PIN_B5  = 0;
  localparam int PIN_B0  = 1;
  localparam int PIN_B1  = 2;
  localparam int PIN_TCK = 3;
  localparam int PIN_TMS = 4;
  localparam int PIN_TDI = 5;
  localparam int PIN_TDO = 6;
  localparam int NPINS   = 7;
  // per-pin function select codes for the port b lines
  localparam logic [1:0] FN_PORT = 2'h0;  // general-purpose line
  localparam logic [1:0] FN_ALT1 = 2'h1;  // timer / spi function
  localparam logic [1:0] FN_ALT2 = 2'h2;  // fault / i2c function
  // test pin select bit: 0 keeps the test function
  localparam logic TEST_FN_JTAG = 1'b0;
  // values after reset
  localparam logic [1:0] SEL_RESET      = 2'h0;
  localparam logic [3:0] TEST_SEL_RESET = 4'h0;
  localparam logic [6:0] PULL_IN_RESET  = 7'h3f;  // all but the test output
  localparam logic [6:0] JTAG_IN_MASK   = 7'h38;  // tck, tms, tdi
  // test port sizes
  localparam int IR_WIDTH = 4;
  localparam int DR_WIDTH = 32;
  localparam logic [3:0] IR_CAPTURE  = 4'h1;
  localparam logic [3:0] IR_IDCODE   = 4'h2;
  localparam logic [3:0] IR_BYPASS   = 4'hf;
  localparam logic [31:0] ID_DEFAULT = 32'h0000_0001;  // arbitrary value
  // pwm channel count
  localparam int PWM_CHANNELS = 6;
  // tap controller states
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } tap_state_t;
endpackage

// *** dv/jtag_probe.sv ***
// Purpose: behavioural test probe on the test clock, mode and data pads
// Assumes: the bench routes these outputs onto pads three to five
// Notes:   tck rests low between steps, so the link clock only runs in frames
`timescale 1ns/100ps
module jtag_probe #(
  parameter real HALF = 62.5  // half of the 125 ns test clock period
) (
  // lines toward the device
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  // lines from the device
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  // idle levels: clock low, mode and data high like the pull-ups
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // one clock period; mode and data set while low, output read at the rise
  task automatic step(input logic tms_v, input logic tdi_v, output logic tdo_v,
                      output logic oe_v);
    tms = tms_v;
    tdi = tdi_v;
    #(HALF);
    tck = 1'b1;
    // device changes its output on the fall, so the rise sees a settled bit
    tdo_v = tdo;
    oe_v = tdo_oe;
    #(HALF);
    tck = 1'b0;
  endtask
endmodule

// *** dv/tb.sv ***
// Purpose: self-checking bench for the pin function mux
// Assumes: inputs other than the probe lines change on the falling edge of clk_sys
// Notes:   undriven pads without pull-up read the inverse of their last level
`timescale 1ns/100ps
module tb import pin_mux_pkg::*;;
  // clock, reset and selects
  logic                    clk_sys = 1'b0;
  logic                    nrst;
  logic [1:0]              b5_sel, b0_sel, b1_sel;
  logic [3:0]              test_pin_sel;
  // port mode and peripheral sides
  logic [6:0]              gpio_out, gpio_dir, gpio_in;
  logic                    t_out, t_oe, t_in;
  logic [PWM_CHANNELS-1:0] pwm_in, pwm_fault_sel, pwm_out;
  logic                    fault, spi_master, spi_sclk_out, spi_sclk_in;
  logic                    spi_ss_n, spi_selected, scl_pull_low, sda_pull_low;
  logic                    scl_in, sda_in, jtag_shifting;
  // pads and the outside world
  logic [6:0]              pin_out, pin_oe, pin_pull, pad, last_pad, ext_en, ext_val;
  logic                    tck_p, tms_p, tdi_p;
  logic [31:0]             tdo_bits, oe_bits;
  int                      err_count = 0;
  int                      compares = 0;

  always #20 clk_sys = ~clk_sys;

  // pad level: device drive wins, then outside drive, then pull-up, else drift
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      if (pin_oe[i]) pad[i] = pin_out[i];
      else if (ext_en[i]) pad[i] = (i == 3) ? tck_p : (i == 4) ? tms_p :
                                   (i == 5) ? tdi_p : ext_val[i];
      else if (pin_pull[i]) pad[i] = 1'b1;
      else pad[i] = ~last_pad[i];
    end
  end
  // memory of the last level, so a released pad without pull-up never keeps it
  always @(posedge clk_sys) last_pad <= pad;

  pin_function_mux i_dut (
    .clk_sys(clk_sys), .tck(pad[3]), .nrst(nrst),
    .port_b_line_five_sel(b5_sel), .port_b_line_zero_sel(b0_sel),
    .port_b_line_one_sel(b1_sel), .test_pin_sel(test_pin_sel),
    .gpio_out(gpio_out), .gpio_dir(gpio_dir), .gpio_in(gpio_in),
    .timer_channel_one_out(t_out), .timer_channel_one_oe(t_oe),
    .timer_channel_one_in(t_in), .pwm_in(pwm_in), .pwm_fault_sel(pwm_fault_sel),
    .pwm_out(pwm_out), .external_pwm_fault_input(fault), .spi_master(spi_master),
    .spi_sclk_out(spi_sclk_out), .spi_sclk_in(spi_sclk_in), .spi_ss_n(spi_ss_n),
    .spi_selected(spi_selected), .scl_pull_low(scl_pull_low),
    .sda_pull_low(sda_pull_low), .scl_in(scl_in), .sda_in(sda_in),
    .jtag_shifting(jtag_shifting), .pin_in(pad), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pull(pin_pull)
  );

  jtag_probe i_probe (
    .tck(tck_p), .tms(tms_p), .tdi(tdi_p), .tdo(pad[6]), .tdo_oe(pin_oe[6])
  );

  // one comparison, counted, reported at once on mismatch
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // run n test clock steps, collecting output bits and enables lsb first
  task automatic tap_seq(input logic [31:0] tms_v, input logic [31:0] tdi_v, input int n);
    logic b, e;
    tdo_bits = '0;
    oe_bits = '0;
    for (int k = 0; k < n; k++) begin
      i_probe.step(tms_v[k], tdi_v[k], b, e);
      tdo_bits[k] = b;
      oe_bits[k] = e;
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // hang guard: a run that overstays counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    give_verdict();
  end

  initial begin
    nrst = 1'b0;
    {b5_sel, b0_sel, b1_sel, test_pin_sel} = '0;
    {gpio_out, gpio_dir, t_out, t_oe, pwm_in, pwm_fault_sel} = '0;
    {spi_master, spi_sclk_out, scl_pull_low, sda_pull_low} = '0;
    ext_en = 7'h38;
    ext_val = 7'h00;
    last_pad = 7'h00;
    wait_cyc(3);
    check("pin_oe", 7'h00, pin_oe);
    check("pin_pull", PULL_IN_RESET, pin_pull);
    check("spi_ss_n", 1, spi_ss_n);
    check("pwm_out", 0, pwm_out);
    nrst = 1'b1;
    wait_cyc(8);
    check("pin_oe", 7'h00, pin_oe);
    check("pin_pull", JTAG_IN_MASK, pin_pull);
    // port mode: two direction patterns, data only on outputs
    for (int p = 0; p < 2; p++) begin
      gpio_dir = p ? 7'h02 : 7'h05;
      gpio_out = p ? 7'h02 : 7'h01;
      wait_cyc(3);
      check("pin_oe", gpio_dir, pin_oe);
      check("pin_out", gpio_out, pin_out & gpio_dir);
    end
    gpio_dir = 7'h00;
    ext_en = 7'h3f;
    ext_val = 7'h05;
    wait_cyc(3);
    check("gpio_in", 3'h5, gpio_in[2:0]);
    // timer channel on line five, direction from the timer, not from the port
    ext_en[0] = 1'b0;
    gpio_dir[0] = 1'b1;
    b5_sel = FN_ALT1;
    {t_oe, t_out} = 2'b11;
    wait_cyc(3);
    check("t_drive", 2'b11, {pin_oe[0], pin_out[0]});
    t_oe = 1'b0;
    ext_en[0] = 1'b1;
    ext_val[0] = 1'b1;
    wait_cyc(3);
    check("t_in", 2'b01, {pin_oe[0], t_in});
    // fault input gates only the selected pwm outputs
    b5_sel = FN_ALT2;
    pwm_in = 6'h3f;
    pwm_fault_sel = 6'h0f;
    ext_val[0] = 1'b0;
    wait_cyc(4);
    check("pwm_clear", 7'h3f, {fault, pwm_out});
    ext_val[0] = 1'b1;
    wait_cyc(4);
    check("pwm_fault", 8'h70, {pin_oe[0], fault, pwm_out});
    // spi clock on line zero: output as master, input as slave
    b0_sel = FN_ALT1;
    {spi_master, spi_sclk_out} = 2'b11;
    wait_cyc(3);
    check("sclk_out", 2'b11, {pin_oe[1], pin_out[1]});
    spi_master = 1'b0;
    ext_val[1] = 1'b1;
    wait_cyc(3);
    check("sclk_in", 2'b01, {pin_oe[1], spi_sclk_in});
    // slave select on line one, low addresses the device
    b1_sel = FN_ALT1;
    ext_val[2] = 1'b0;
    wait_cyc(3);
    check("ss_low", 2'b01, {spi_ss_n, spi_selected});
    ext_val[2] = 1'b1;
    wait_cyc(3);
    check("ss_high", 2'b10, {spi_ss_n, spi_selected});
    // i2c lines with outside pull-ups: device pulls clock, peer pulls data
    b0_sel = FN_ALT2;
    b1_sel = FN_ALT2;
    scl_pull_low = 1'b1;
    ext_val[2] = 1'b0;
    wait_cyc(4);
    check("scl", 2'b00, {pad[1], scl_in});
    check("sda", 2'b00, {pin_oe[2], sda_in});
    scl_pull_low = 1'b0;
    ext_val[2:1] = 2'b11;
    wait_cyc(4);
    check("i2c_rel", 2'b11, {scl_in, sda_in});
    // test port: reset, capture ir while loading bypass
    tap_seq(32'h1f, 0, 5);
    check("tdo_oe_idle", 0, oe_bits[4:0]);
    tap_seq(32'h06, 0, 5);
    tap_seq(32'h8, 32'(IR_BYPASS), 4);
    check("ir_capture", IR_CAPTURE, tdo_bits[3:0]);
    check("ir_oe", 4'hf, oe_bits[3:0]);
    tap_seq(32'h3, 0, 4);
    wait_cyc(4);
    check("shifting", 1, jtag_shifting);
    tap_seq(32'h80, 32'ha5, 8);
    check("bypass", 8'h4a, tdo_bits[7:0]);
    tap_seq(32'h1, 0, 2);
    wait_cyc(4);
    check("idle", 2'b00, {jtag_shifting, pin_oe[6]});
    // id register after a tms reset
    tap_seq(32'h5f, 0, 9);
    tap_seq(32'h8000_0000, 0, 32);
    check("idcode", ID_DEFAULT, tdo_bits);
    tap_seq(32'h1, 0, 2);
    wait_cyc(1);
    // test output pad falls back to a port d line
    test_pin_sel = 4'h8;
    gpio_dir[6] = 1'b1;
    gpio_out[6] = 1'b1;
    wait_cyc(4);
    check("port_d", 2'b11, {pin_oe[6], pin_out[6]});
    give_verdict();
  end
endmodule

// *** rtl/pin_function_mux.sv ***
// Purpose: function mux for three port b pins and the four test pins
// Assumes: selects come from the system integration module on clk_sys
// Notes:   pin_in[3] and tck are the same pad; tck clocks the tap
//
// What this block does
// RL1: reset: inputs with pull-up, test output excepted
// RL2: port mode direction set per pin
// RL3: function chosen by integration module selects
// RL4: line five: port, timer channel, fault
// RL5: asserted fault input disables selected pwm
// RL6: test pins default jtag, else port d
// RL7: probe gates tck; test logic uses it
// RL8: tms sampled on rising tck steps tap
// RL9: tdi sampled on rising tck
// RL10: tdo driven only in shift states
// RL11: tdo updated on falling tck
// RL12: line zero: port, spi clock, i2c clock
// RL13: spi clock out as master, in as slave
// RL14: line one: port, slave select, i2c data
// RL15: low slave select addresses this device
// RL16: per-pin select resets to default, routes enables
`timescale 1ns/100ps
module pin_function_mux import pin_mux_pkg::*; #(
  parameter int          PWM_CH = PWM_CHANNELS,  // pwm outputs gated by fault
  parameter logic [31:0] IDCODE = ID_DEFAULT     // arbitrary value
) (
  // clocks and reset
  input  wire logic              clk_sys,
  input  wire logic              tck,
  input  wire logic              nrst,
  // function selects from the system integration module
  input  wire logic [1:0]        port_b_line_five_sel,
  input  wire logic [1:0]        port_b_line_zero_sel,
  input  wire logic [1:0]        port_b_line_one_sel,
  input  wire logic [3:0]        test_pin_sel,
  // port mode data and direction, one bit per pin
  input  wire logic [6:0]        gpio_out,
  input  wire logic [6:0]        gpio_dir,
  output logic      [6:0]        gpio_in,
  // timer channel one
  input  wire logic              timer_channel_one_out,
  input  wire logic              timer_channel_one_oe,
  output logic                   timer_channel_one_in,
  // pwm fault gating
  input  wire logic [PWM_CH-1:0] pwm_in,
  input  wire logic [PWM_CH-1:0] pwm_fault_sel,
  output logic      [PWM_CH-1:0] pwm_out,
  output logic                   external_pwm_fault_input,
  // spi clock and slave select
  input  wire logic              spi_master,
  input  wire logic              spi_sclk_out,
  output logic                   spi_sclk_in,
  output logic                   spi_ss_n,
  output logic                   spi_selected,
  // i2c open-drain lines
  input  wire logic              scl_pull_low,
  input  wire logic              sda_pull_low,
  output logic                   scl_in,
  output logic                   sda_in,
  // test port status
  output logic                   jtag_shifting,
  // pads
  input  wire logic [6:0]        pin_in,
  output logic      [6:0]        pin_out,
  output logic      [6:0]        pin_oe,
  output logic      [6:0]        pin_pull
);
  logic [1:0] rst_pipe;      // reset release synchroniser
  logic       rst_n;         // released reset copy
  logic [6:0] sync1;         // first pad sampling stage
  logic [6:0] sync2;         // second pad sampling stage
  logic [1:0] sel_b5;        // held select, line five
  logic [1:0] sel_b0;        // held select, line zero
  logic [1:0] sel_b1;        // held select, line one
  logic [3:0] sel_test;      // held select, test pins
  logic [6:0] drive;         // registered pad data
  logic [6:0] oe;            // registered pad enable
  logic [6:0] next_drive;
  logic [6:0] next_oe;
  logic       fault_on;      // fault input selected and high
  logic       tap_run;       // tap allowed to leave reset
  logic       tap_tdo;       // tck-domain output bit
  logic       tap_tdo_oe;    // tck-domain output enable
  logic       tap_shift;     // tck-domain shift flag
  logic [1:0] shift_sync;    // shift flag crossing
  logic       tdo_as_jtag;   // tdo pad keeps its test function

  // reset asserts at once, releases after two clk_sys edges
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) rst_pipe <= 2'h0;
    else       rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_n = rst_pipe[1];

  // pads come from outside, two stages before the clk_sys logic looks; the tap takes tck, tms and tdi raw
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
    end
  end

  // selects held here so every pin has a defined default after reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel_b5   <= SEL_RESET;       // RL4 RL16
      sel_b0   <= SEL_RESET;       // RL12
      sel_b1   <= SEL_RESET;       // RL14
      sel_test <= TEST_SEL_RESET;  // RL6
    end else begin
      sel_b5   <= port_b_line_five_sel;  // RL3
      sel_b0   <= port_b_line_zero_sel;
      sel_b1   <= port_b_line_one_sel;
      sel_test <= test_pin_sel;
    end
  end

  // pad data and enable per selected function; port mode is the fallback
  always_comb begin
    next_drive = gpio_out;  // RL2
    next_oe    = gpio_dir;  // RL2
    // line five: timer channel both ways, fault input only
    case (sel_b5)
      FN_ALT1: begin
        next_drive[PIN_B5] = timer_channel_one_out;  // RL4
        next_oe[PIN_B5]    = timer_channel_one_oe;
      end
      FN_ALT2: begin
        next_drive[PIN_B5] = 1'b0;
        next_oe[PIN_B5]    = 1'b0;  // RL4
      end
      default: begin
      end
    endcase
    // line zero: spi clock follows master mode, i2c clock open drain
    case (sel_b0)
      FN_ALT1: begin
        next_drive[PIN_B0] = spi_sclk_out;
        next_oe[PIN_B0]    = spi_master;  // RL13
      end
      FN_ALT2: begin
        next_drive[PIN_B0] = 1'b0;
        next_oe[PIN_B0]    = scl_pull_low;  // RL12
      end
      default: begin
      end
    endcase
    // line one: slave select input, i2c data open drain
    case (sel_b1)
      FN_ALT1: begin
        next_drive[PIN_B1] = 1'b0;
        next_oe[PIN_B1]    = 1'b0;  // RL14
      end
      FN_ALT2: begin
        next_drive[PIN_B1] = 1'b0;
        next_oe[PIN_B1]    = sda_pull_low;  // RL14
      end
      default: begin
      end
    endcase
    // test input pins never drive while they keep the test function
    for (int i = 0; i < 3; i++) begin
      if (sel_test[i] == TEST_FN_JTAG) begin
        next_drive[PIN_TCK+i] = 1'b0;
        next_oe[PIN_TCK+i]    = 1'b0;  // RL6
      end
    end
    if (sel_test[3] == TEST_FN_JTAG) begin
      next_drive[PIN_TDO] = 1'b0;
      next_oe[PIN_TDO]    = 1'b0;
    end
  end

  // pad flops; enables stay low until the reset copy releases
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      drive <= '0;
      oe    <= '0;  // RL1
    end else begin
      drive <= next_drive;
      oe    <= next_oe;  // RL16
    end
  end

  // tdo pad takes the tck-domain flops directly; resampling would miss
  // the falling-edge timing the probe relies on
  assign tdo_as_jtag = (sel_test[3] == TEST_FN_JTAG);
  always_comb begin
    pin_out = drive;
    pin_oe  = oe;
    if (tdo_as_jtag) begin
      pin_out[PIN_TDO] = tap_tdo;     // RL11
      pin_oe[PIN_TDO]  = tap_tdo_oe;  // RL10
    end
  end

  // pull-ups on every pad but the test output in reset; test inputs keep theirs after
  always_comb begin
    if (!rst_n) pin_pull = PULL_IN_RESET;  // RL1
    else        pin_pull = JTAG_IN_MASK & ~pin_oe;
  end

  // sampled pad levels toward software and the peripherals
  assign gpio_in              = sync2;
  assign timer_channel_one_in = (sel_b5 == FN_ALT1) & sync2[PIN_B5];
  assign spi_sclk_in          = (sel_b0 == FN_ALT1) & ~spi_master & sync2[PIN_B0];  // RL13
  assign scl_in               = (sel_b0 != FN_ALT2) | sync2[PIN_B0];
  assign sda_in               = (sel_b1 != FN_ALT2) | sync2[PIN_B1];
  // unselected slave select reads as released, so no stray transfer
  assign spi_ss_n             = (sel_b1 != FN_ALT1) | sync2[PIN_B1];  // RL15
  assign spi_selected         = ~spi_ss_n;                            // RL15

  // fault path: one flop so pwm gating and flag line up
  assign fault_on = (sel_b5 == FN_ALT2) & sync2[PIN_B5];
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pwm_out                  <= '0;
      external_pwm_fault_input <= 1'b0;
    end else begin
      pwm_out                  <= pwm_in & ~(pwm_fault_sel & {PWM_CH{fault_on}});  // RL5
      external_pwm_fault_input <= fault_on;
    end
  end

  // tap may run only while tck and tms keep their test function
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) tap_run <= 1'b0;
    else        tap_run <= (sel_test[0] == TEST_FN_JTAG) && (sel_test[1] == TEST_FN_JTAG);
  end

  // test port on the probe's gated clock
  tap_controller #(
    .IDCODE (IDCODE)
  ) u_tap (
    .tck      (tck),              // RL7
    .run      (tap_run),
    .tms      (pin_in[PIN_TMS]),  // RL8
    .tdi      (pin_in[PIN_TDI]),  // RL9
    .tdo      (tap_tdo),
    .tdo_oe   (tap_tdo_oe),
    .shifting (tap_shift)
  );

  // shift flag level crosses into clk_sys through two flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) shift_sync <= 2'h0;
    else        shift_sync <= {shift_sync[0], tap_shift};
  end
  assign jtag_shifting = shift_sync[1];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence fault_seen_s;
    (sel_b5 == FN_ALT2) && sync2[PIN_B5];
  endsequence
  sequence fault_gate_s;
    (pwm_out & pwm_fault_sel) == '0;
  endsequence

  reset_pull_a: assert property (!rst_n |-> pin_pull == 7'h3f && oe == 7'h00)  // RL1
    else $error("pads not inputs with pull-up in reset");
  sel_default_a: assert property ($rose(rst_n) |->  // RL16
    sel_b5 == 2'h0 && sel_b0 == 2'h0 && sel_b1 == 2'h0 && sel_test == 4'h0)
    else $error("selects not at default after reset");
  port_dir_a: assert property (rst_n && sel_b5 == FN_PORT  // RL2
    |=> pin_oe[PIN_B5] == $past(gpio_dir[PIN_B5]) &&
        pin_out[PIN_B5] == $past(gpio_out[PIN_B5]))
    else $error("port mode direction not followed");
  timer_route_a: assert property (rst_n && sel_b5 == FN_ALT1  // RL4
    |=> pin_oe[PIN_B5] == $past(timer_channel_one_oe))
    else $error("timer enable not routed");
  fault_gate_a: assert property (rst_n && $past(rst_n) ##0 fault_seen_s  // RL5
    |=> fault_gate_s) else $error("pwm not disabled on fault");
  spi_clk_a: assert property (rst_n && sel_b0 == FN_ALT1  // RL13
    |=> pin_oe[PIN_B0] == $past(spi_master))
    else $error("spi clock direction wrong");
  ss_idle_a: assert property (sel_b1 != FN_ALT1 |-> spi_ss_n && !spi_selected)  // RL15
    else $error("slave select active while unselected");
  ss_follow_a: assert property (rst_n && sel_b1 == FN_ALT1 && $stable(sel_b1)  // RL14
    |-> spi_ss_n == $past(pin_in[PIN_B1], 2))
    else $error("slave select not sampled");
  test_in_a: assert property (sel_test[2:0] == 3'h0 |=> pin_oe[5:3] == 3'h0)  // RL6
    else $error("test input pad driven");
  i2c_od_a: assert property (rst_n && sel_b1 == FN_ALT2  // RL14
    |=> pin_out[PIN_B1] == 1'b0) else $error("i2c line driven high");

  // enables and levels one edge after the held select; a driven pad must
  // drop its pull-up, otherwise a low drive would fight it and waste current
  tdo_port_a: assert property (rst_n && sel_test[3] != TEST_FN_JTAG  // RL6
    |=> sel_test[3] == TEST_FN_JTAG || pin_oe[PIN_TDO] == $past(gpio_dir[PIN_TDO]))
    else $error("port d line on test output not routed");
  scl_od_a: assert property (rst_n && sel_b0 == FN_ALT2  // RL12
    |=> pin_out[PIN_B0] == 1'b0 && pin_oe[PIN_B0] == $past(scl_pull_low))
    else $error("i2c clock not open drain");
  pull_drive_a: assert property (rst_n |-> (pin_pull & pin_oe) == 7'h00)  // RL1
    else $error("pull-up left on a driven pad");
  fault_free_a: assert property (rst_n && !fault_on  // RL5
    |=> pwm_out == $past(pwm_in)) else $error("pwm gated without fault");
  shift_cross_a: assert property (rst_n && $past(rst_n, 2)  // RL10
    |-> jtag_shifting == $past(tap_shift, 2))
    else $error("shift flag not carried across");
endmodule

// *** rtl/tap_controller.sv ***
// Purpose: test access port state machine on the test clock
// Assumes: run is a level from the system clock domain
// Notes:   reset is asserted at once and released after two tck edges
`timescale 1ns/100ps
module tap_controller import pin_mux_pkg::*; #(
  parameter logic [31:0] IDCODE = ID_DEFAULT  // arbitrary value
) (
  // test clock and enable level
  input  wire logic tck,
  input  wire logic run,
  // serial pins
  input  wire logic tms,
  input  wire logic tdi,
  output logic      tdo,
  output logic      tdo_oe,
  // status toward the system domain
  output logic      shifting
);
  logic [1:0]          rst_pipe;  // release synchroniser on tck
  logic                trst_n;    // local reset
  tap_state_t          state;     // controller state
  tap_state_t          next_state;
  logic [IR_WIDTH-1:0] ir_sh;     // instruction shift stage
  logic [IR_WIDTH-1:0] ir;        // current instruction
  logic [DR_WIDTH-1:0] dr_sh;     // identification shift stage
  logic                byp;       // bypass stage
  logic                next_tdo;

  assign trst_n = rst_pipe[1];

  // reset asserts with run low, releases on tck so the clock may stand still
  always_ff @(posedge tck or negedge run) begin
    if (!run) rst_pipe <= 2'h0;
    else      rst_pipe <= {rst_pipe[0], 1'b1};
  end

  // tms steps the controller on each rising tck edge
  always_comb begin
    case (state)
      TLR:     next_state = tms ? TLR    : RTI;
      RTI:     next_state = tms ? SEL_DR : RTI;
      SEL_DR:  next_state = tms ? SEL_IR : CAP_DR;
      CAP_DR:  next_state = tms ? EX1_DR : SH_DR;
      SH_DR:   next_state = tms ? EX1_DR : SH_DR;
      EX1_DR:  next_state = tms ? UPD_DR : PA_DR;
      PA_DR:   next_state = tms ? EX2_DR : PA_DR;
      EX2_DR:  next_state = tms ? UPD_DR : SH_DR;
      UPD_DR:  next_state = tms ? SEL_DR : RTI;
      SEL_IR:  next_state = tms ? TLR    : CAP_IR;
      CAP_IR:  next_state = tms ? EX1_IR : SH_IR;
      SH_IR:   next_state = tms ? EX1_IR : SH_IR;
      EX1_IR:  next_state = tms ? UPD_IR : PA_IR;
      PA_IR:   next_state = tms ? EX2_IR : PA_IR;
      EX2_IR:  next_state = tms ? UPD_IR : SH_IR;
      default: next_state = tms ? SEL_DR : RTI;
    endcase
  end

  // state register
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) state <= TLR;
    else         state <= next_state;  // RL7 RL8
  end

  // instruction path, tdi sampled on the rising edge
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      ir_sh <= IR_IDCODE;
      ir    <= IR_IDCODE;
    end else begin
      if (state == CAP_IR)     ir_sh <= IR_CAPTURE;
      else if (state == SH_IR) ir_sh <= {tdi, ir_sh[IR_WIDTH-1:1]};  // RL9
      if (state == TLR)        ir <= IR_IDCODE;
      else if (state == UPD_IR) ir <= ir_sh;
    end
  end

  // data path: identification or bypass
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      dr_sh <= '0;
      byp   <= 1'b0;
    end else if (state == CAP_DR) begin
      dr_sh <= IDCODE;
      byp   <= 1'b0;
    end else if (state == SH_DR) begin
      dr_sh <= {tdi, dr_sh[DR_WIDTH-1:1]};  // RL9
      byp   <= tdi;
    end
  end

  // output bit picked from the stage being shifted
  always_comb begin
    if (state == SH_IR)      next_tdo = ir_sh[0];
    else if (ir == IR_BYPASS) next_tdo = byp;
    else                      next_tdo = dr_sh[0];
  end

  // tdo changes on the falling edge, driven only while shifting
  always_ff @(negedge tck or negedge trst_n) begin
    if (!trst_n) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo    <= next_tdo;                              // RL11
      tdo_oe <= (state == SH_IR) || (state == SH_DR);  // RL10
    end
  end

  // shift flag for the system domain, a flop so it is glitch free
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) shifting <= 1'b0;
    else         shifting <= (next_state == SH_IR) || (next_state == SH_DR);
  end

  sequence five_ones_s;
    tms [*5];
  endsequence
  tap_reset_a: assert property (@(posedge tck) disable iff (!trst_n)  // RL8
    five_ones_s |=> state == TLR) else $error("tap not reset by tms");
  tdo_drive_a: assert property (@(posedge tck) disable iff (!trst_n)  // RL10
    tdo_oe |-> state == SH_IR || state == SH_DR) else $error("tdo driven");
  tdo_value_a: assert property (@(posedge tck) disable iff (!trst_n)  // RL11
    state == SH_IR && tdo_oe |-> tdo == ir_sh[0]) else $error("tdo wrong");
  bypass_a: assert property (@(posedge tck) disable iff (!trst_n)  // RL9
    state == SH_DR |=> byp == $past(tdi)) else $error("tdi not sampled");
endmodule
